/* hw/sacm_top.sv */
// alarm latch, clear acceptance, stop selection and register port
// assumes: drive logic on i_clk raises alarms; clear input is a raw pin
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - overload alarm clear held pending until ten seconds, then performed
// - absolute-down and overspeed alarms need encoder reset before clearing
// - non-clearable alarms stay latched until power cycle
// - non-comm alarm: comm clear accepted only with clear input off or unassigned
// - rising edge on clear input clears clearable non-comm alarm
// - non-comm alarm: comm clear with clear input on is dropped; release input, repeat
// - estop-attribute alarm with sequence select 4..7 starts emergency stop
// - comm alarm indication lags the alarm itself
// - retract clear attribute bits 0..2 make retract alarms clearable
// - under retract condition alarm waits for retract completion
// - alarm after retract completion acts as emergency stop alarm
// - comm alarm decelerates per fault reaction setting
// - command error 2 logged and clearable
// - encoder recovery alarm logged, not clearable
// - motor recognition alarms neither logged nor clearable
// - home return error 2 logged and clearable
// - control unit and comm hardware alarms not clearable; logged except comm hardware sub-code 5
module sacm_top
   import sacm_pkg::*;
#(
   parameter int OVL_CYC = OVL_HOLD_CYC,
   parameter int IND_CYC = IND_LAG_CYC
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic [2:0]  i_addr,
   input  wire logic [DW-1:0] i_wdata,
   input  wire logic        i_we,
   input  wire logic        i_re,
   output logic [DW-1:0]    o_rdata,
   input  wire logic        i_alarm_raise,
   input  wire sacm_code_t  i_alarm_code,
   input  wire logic        i_retract_cond,
   input  wire logic        i_retract_done,
   input  wire logic        i_comm_clear,
   input  wire logic        i_alarm_clear_input,
   input  wire logic        i_abs_enc_reset,
   output logic            o_alarm,
   output sacm_code_t      o_alarm_code,
   output logic            o_estop,
   output logic            o_fault_decel,
   output logic [2:0]      o_fault_reaction,
   output logic            o_retract_active,
   output logic            o_ind_alarm,
   output logic            o_hist_wr,
   output sacm_code_t      o_hist_code,
   output logic            o_irq
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      sacm_mode_t        mode;
      sacm_code_t        code;
      logic [31:0]       ovl_cnt;
      logic [31:0]       ind_cnt;
      logic              enc_ok;
      logic              pend;
      logic              estop;
      logic              decel;
      logic              ind;
      logic              clr_prev;
      logic              hist_wr;
      sacm_code_t        hist_code;
      logic [DW-1:0]     ctrl;
      logic [ST_W-1:0]   stat;
      logic [ST_W-1:0]   mask;
      logic [DW-1:0]     rdata;
   } sacm_state_t;

   sacm_state_t s, next_s;
   sacm_attr_t  a_in, a_st;
   logic        clr_lvl;
   logic        clr_edge, in_on, comm_req, enc_req, any_req;
   logic        want, ok, ovl_wait, is_ovl, is_abs, ret_code;
   logic [2:0]  seq;
   logic [ST_W-1:0] set;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   sacm_sync u_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_pin   (i_alarm_clear_input),
      .o_level (clr_lvl)
   );
   // incoming code decides stop action, stored code decides clearing
   sacm_attr u_attr_in (
      .i_code     (i_alarm_code),
      .i_ret_attr (s.ctrl[RET_LSB +: 3]),
      .o_attr     (a_in)
   );
   sacm_attr u_attr_st (
      .i_code     (s.code),
      .i_ret_attr (s.ctrl[RET_LSB +: 3]),
      .o_attr     (a_st)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_s         = s;
      next_s.hist_wr = 1'b0;
      next_s.rdata   = '0;
      set            = '0;
      seq      = s.ctrl[SEQ_LSB +: 3];
      clr_edge = clr_lvl & ~s.clr_prev;
      next_s.clr_prev = clr_lvl;
      in_on    = s.ctrl[ASN_BIT] & clr_lvl;
      comm_req = i_comm_clear | (i_we & (i_addr == REG_CMD) & i_wdata[CMD_CLR]);
      enc_req  = i_abs_enc_reset | (i_we & (i_addr == REG_CMD) & i_wdata[CMD_ENC]);
      any_req  = comm_req | clr_edge;
      is_ovl   = (s.code.main == M_OVL) & (s.code.sub == S_ZERO);
      is_abs   = ((s.code.main == M_ABS1) | (s.code.main == M_ABS2))
                 & (s.code.sub == S_ZERO);
      ret_code = (i_alarm_code.main == M_RET) & (i_alarm_code.sub != S_ZERO)
                 & (i_alarm_code.sub <= S_3);
      // comm alarms take comm clears whatever the input does
      want     = (comm_req & (a_st.comm | ~in_on))
                 | (clr_edge & ~a_st.comm)
                 | s.pend;
      ok       = a_st.clr & ~(is_abs & ~s.enc_ok);
      ovl_wait = is_ovl & (s.ovl_cnt < 32'(OVL_CYC));
      case (s.mode)
         MODE_IDLE: begin
            if (i_alarm_raise) begin
               next_s.code    = i_alarm_code;
               next_s.ovl_cnt = '0;
               next_s.ind_cnt = '0;
               next_s.enc_ok  = 1'b0;
               next_s.pend    = 1'b0;
               if (ret_code & i_retract_cond) begin
                  next_s.mode = MODE_RETRACT;
               end else begin
                  next_s.mode      = MODE_LATCHED;
                  next_s.hist_wr   = a_in.hist;
                  next_s.hist_code = i_alarm_code;
                  next_s.estop     = a_in.estop & (seq >= SEQ_EMIN)
                                     & (seq <= SEQ_EMAX);
                  next_s.decel     = a_in.comm;
                  next_s.ind       = ~a_in.comm;
                  set[ST_RAISE]    = 1'b1;
                  set[ST_ESTOP]    = next_s.estop;
               end
            end
         end
         MODE_RETRACT: begin
            // retract owns the stop; alarm shows only on completion
            if (i_retract_done) begin
               next_s.mode      = MODE_LATCHED;
               next_s.hist_wr   = a_st.hist;
               next_s.hist_code = s.code;
               next_s.estop     = 1'b1;
               next_s.ind       = 1'b1;
               set[ST_RAISE]    = 1'b1;
               set[ST_ESTOP]    = 1'b1;
            end
         end
         MODE_LATCHED: begin
            if (s.ovl_cnt < 32'(OVL_CYC)) begin
               next_s.ovl_cnt = s.ovl_cnt + 32'h1;
            end
            if (!s.ind) begin
               next_s.ind_cnt = s.ind_cnt + 32'h1;
               next_s.ind     = (s.ind_cnt >= 32'(IND_CYC - 1));
            end
            if (enc_req) begin
               next_s.enc_ok = 1'b1;
            end
            if (want & ok & ~ovl_wait) begin
               next_s.mode  = MODE_IDLE;
               next_s.pend  = 1'b0;
               next_s.estop = 1'b0;
               next_s.decel = 1'b0;
               next_s.ind   = 1'b0;
               set[ST_CLEAR] = 1'b1;
            end else if (want & ok) begin
               next_s.pend = 1'b1;
            end else if (any_req) begin
               set[ST_REFUS] = 1'b1;
            end
         end
         default: next_s.mode = MODE_IDLE;
      endcase
      // ----------------------------------------------------------------
      // register port
      // ----------------------------------------------------------------
      if (i_we && i_addr == REG_CTRL) begin
         next_s.ctrl = i_wdata;
      end
      if (i_we && i_addr == REG_MASK) begin
         next_s.mask = i_wdata[ST_W-1:0];
      end
      // read clears status, but a same-cycle event survives
      if (i_re && i_addr == REG_STAT) begin
         next_s.stat = set;
      end else begin
         next_s.stat = s.stat | set;
      end
      if (i_re) begin
         case (i_addr)
            REG_CTRL: next_s.rdata = s.ctrl;
            REG_ALRM: next_s.rdata = {s.mode == MODE_LATCHED, 3'h0, s.code};
            REG_STAT: next_s.rdata = {12'h000, s.stat};
            REG_MASK: next_s.rdata = {12'h000, s.mask};
            default:  next_s.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s      <= '0;
         s.mode <= MODE_IDLE;
         s.ctrl <= CTRL_RST;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_rdata          = s.rdata;
   assign o_alarm          = (s.mode == MODE_LATCHED);
   assign o_alarm_code     = s.code;
   assign o_estop          = s.estop;
   assign o_fault_decel    = s.decel;
   assign o_fault_reaction = s.ctrl[FRA_LSB +: 3];
   assign o_retract_active = (s.mode == MODE_RETRACT);
   assign o_ind_alarm      = s.ind;
   assign o_hist_wr        = s.hist_wr;
   assign o_hist_code      = s.hist_code;
   assign o_irq            = |(s.stat & s.mask);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   chk_ovl_hold: assert property (
      (o_alarm && is_ovl && s.ovl_cnt < 32'(OVL_CYC)) |=> o_alarm)
      else $error("overload alarm cleared too early");
   chk_abs_hold: assert property (
      (o_alarm && is_abs && !s.enc_ok) |=> o_alarm && $stable(o_alarm_code))
      else $error("absolute alarm cleared without encoder reset");
   chk_noclr_keep: assert property (
      (o_alarm && !a_st.clr && any_req) |=> o_alarm && $stable(o_alarm_code))
      else $error("non-clearable alarm released");
   chk_comm_block: assert property (
      (o_alarm && !a_st.comm && in_on && comm_req && !clr_edge && !s.pend)
      |=> o_alarm)
      else $error("comm clear taken with clear input on");
   chk_edge_clear: assert property (
      (o_alarm && clr_edge && a_st.clr && !a_st.comm && !is_abs && !is_ovl)
      |=> !o_alarm ##1 s.stat[ST_CLEAR] || $past(i_re))
      else $error("clear input edge did not clear");
   chk_estop_seq: assert property (
      (s.mode == MODE_IDLE && i_alarm_raise && a_in.estop && !ret_code
       && seq >= SEQ_EMIN) |=> o_estop && o_alarm)
      else $error("emergency stop not started");
   chk_ind_lag: assert property (
      ($rose(o_alarm) && a_st.comm) |-> !o_ind_alarm [*2])
      else $error("comm alarm indicated without lag");
   chk_retract_estop: assert property (
      (o_retract_active && i_retract_done) |=> o_alarm && o_estop)
      else $error("retract completion not an emergency stop");
   chk_decel: assert property (
      (o_alarm && a_st.comm) |-> o_fault_decel)
      else $error("comm alarm without fault reaction decel");
   chk_noclr_hold: assert property (
      (o_alarm && !a_st.clr) |=> o_alarm)
      else $error("alarm released without attribute");
   chk_comm_take: assert property (
      (o_alarm && a_st.clr && !a_st.comm && comm_req && !in_on && !is_abs && !is_ovl)
      |=> !o_alarm)
      else $error("comm clear not taken");
   chk_ret_attr: assert property (
      (o_alarm && s.code.main == M_RET && s.code.sub == 4'h1 && !s.ctrl[RET_LSB])
      |=> o_alarm)
      else $error("retract attribute ignored");
   chk_ret_wait: assert property (
      (s.mode == MODE_IDLE && i_alarm_raise && ret_code && i_retract_cond)
      |=> o_retract_active && !o_alarm && !o_estop)
      else $error("alarm before retract end");
   chk_cmd_log: assert property (
      (s.mode == MODE_IDLE && i_alarm_raise && i_alarm_code.main == M_CMD
       && i_alarm_code.sub == S_3) |=> o_hist_wr && a_st.clr)
      else $error("command error 2 attributes");
   chk_home_log: assert property (
      (s.mode == MODE_IDLE && i_alarm_raise && i_alarm_code.main == M_HOME
       && i_alarm_code.sub == S_3) |=> o_hist_wr && a_st.clr)
      else $error("home error 2 attributes");
   chk_mrec_log: assert property (
      (s.mode == MODE_IDLE && i_alarm_raise && i_alarm_code.main == M_MREC)
      |=> o_alarm && !o_hist_wr && !a_st.clr)
      else $error("recognition alarm attributes");
   chk_enc_keep: assert property (
      (o_alarm && s.code.main == M_ENC) |=> o_alarm)
      else $error("recovery alarm released");
   chk_ctl_keep: assert property (
      (o_alarm && (s.code.main == M_CTL || s.code.main == M_CHW))
      |=> o_alarm)
      else $error("hardware alarm released");
   chk_ovl_take: assert property (
      (o_alarm && is_ovl && s.pend && s.ovl_cnt >= 32'(OVL_CYC))
      |=> !o_alarm)
      else $error("held overload clear lost");
   chk_enc_take: assert property (
      (o_alarm && is_abs && s.enc_ok && comm_req && !in_on)
      |=> !o_alarm)
      else $error("absolute clear not taken");
   chk_seq_low: assert property (
      (s.mode == MODE_IDLE && i_alarm_raise && !ret_code && seq < SEQ_EMIN)
      |=> !o_estop)
      else $error("estop below sequence 4");
   chk_ind_now: assert property (
      ($rose(o_alarm) && !a_st.comm) |-> o_ind_alarm)
      else $error("indication late");
   chk_refuse_flag: assert property (
      (o_alarm && !a_st.clr && any_req) |=> s.stat[ST_REFUS])
      else $error("refused clear not flagged");

   // ----------------------------------------------------------------
   // covers
   // ----------------------------------------------------------------
   cov_ovl_pend: cover property (o_alarm && is_ovl && s.pend ##1 !s.pend);
   cov_retract: cover property (o_retract_active ##1 o_alarm);
   cov_comm_clr: cover property (o_alarm && a_st.comm && comm_req ##1 !o_alarm);
   cov_edge_clr: cover property (o_alarm && clr_edge ##1 !o_alarm);
   cov_abs_clr: cover property (o_alarm && is_abs && s.enc_ok ##1 !o_alarm);
endmodule
`default_nettype wire

/* hw/sacm_pkg.sv */
// package: constants and types of the servo alarm clear manager
// assumes: one 100 MHz clock, word-indexed register port
package sacm_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ       = 100_000_000;
   localparam int OVL_HOLD_S   = 10;
   localparam int OVL_HOLD_CYC = OVL_HOLD_S * CLK_HZ;
   localparam int IND_LAG_US   = 1000;
   localparam int IND_LAG_CYC  = IND_LAG_US * (CLK_HZ / 1_000_000);
   // ----------------------------------------------------------------
   // alarm codes
   // ----------------------------------------------------------------
   localparam logic [7:0] M_OVL  = 8'h10;
   localparam logic [7:0] M_ABS1 = 8'h28;
   localparam logic [7:0] M_ABS2 = 8'h2a;
   localparam logic [7:0] M_C80  = 8'h50;
   localparam logic [7:0] M_C81  = 8'h51;
   localparam logic [7:0] M_C85  = 8'h55;
   localparam logic [7:0] M_C88  = 8'h58;
   localparam logic [7:0] M_RET  = 8'h57;
   localparam logic [7:0] M_CMD  = 8'h5b;
   localparam logic [7:0] M_ENC  = 8'h5c;
   localparam logic [7:0] M_PAR  = 8'h5d;
   localparam logic [7:0] M_HOME = 8'h5e;
   localparam logic [7:0] M_MREC = 8'h5f;
   localparam logic [7:0] M_CTL  = 8'h60;
   localparam logic [7:0] M_CHW  = 8'h62;
   localparam logic [3:0] S_ZERO = 4'h0;
   localparam logic [3:0] S_3    = 4'h3;
   localparam logic [3:0] S_5    = 4'h5;
   // ----------------------------------------------------------------
   // registers (word index) and fields
   // ----------------------------------------------------------------
   localparam int         DW       = 16;
   localparam logic [2:0] REG_CTRL = 3'h0;
   localparam logic [2:0] REG_ALRM = 3'h1;
   localparam logic [2:0] REG_STAT = 3'h2;
   localparam logic [2:0] REG_MASK = 3'h3;
   localparam logic [2:0] REG_CMD  = 3'h4;
   localparam int         SEQ_LSB  = 0;
   localparam int         RET_LSB  = 4;
   localparam int         FRA_LSB  = 8;
   localparam int         ASN_BIT  = 12;
   localparam logic [DW-1:0] CTRL_RST = 16'h0000;
   localparam int         CMD_CLR  = 0;
   localparam int         CMD_ENC  = 1;
   localparam int         ST_RAISE = 0;
   localparam int         ST_CLEAR = 1;
   localparam int         ST_REFUS = 2;
   localparam int         ST_ESTOP = 3;
   localparam int         ST_W     = 4;
   localparam logic [2:0] SEQ_EMIN = 3'h4;
   localparam logic [2:0] SEQ_EMAX = 3'h7;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] main;
      logic [3:0] sub;
   } sacm_code_t;
   typedef struct packed {
      logic hist;
      logic clr;
      logic estop;
      logic comm;
   } sacm_attr_t;
   typedef enum logic [1:0] {MODE_IDLE, MODE_RETRACT, MODE_LATCHED} sacm_mode_t;
endpackage

/* hw/sacm_sync.sv */
// two-flop synchroniser for a pin level
// assumes: input is asynchronous to i_clk
`timescale 1ns/1ps
`default_nettype none
module sacm_sync (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_pin,
   output logic      o_level
);
   typedef struct packed {
      logic s1;
      logic s2;
   } sacm_sync_t;
   sacm_sync_t s, next_s;
   always_comb begin
      next_s.s1 = i_pin;
      next_s.s2 = s.s1;
   end
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   assign o_level = s.s2;
endmodule
`default_nettype wire

/* hw/sacm_attr.sv */
// alarm attribute lookup: history, clearable, emergency stop, comm related
// assumes: retract clear attribute bits come from the control register
`timescale 1ns/1ps
`default_nettype none
module sacm_attr
   import sacm_pkg::*;
(
   input  wire sacm_code_t i_code,
   input  wire logic [2:0] i_ret_attr,
   output sacm_attr_t      o_attr
);
   always_comb begin
      // unknown codes stay latched: the safe default
      o_attr = '{hist: 1'b1, clr: 1'b0, estop: 1'b0, comm: 1'b0};
      case (i_code.main)
         M_OVL, M_ABS1, M_ABS2: o_attr.clr = 1'b1;
         M_C80, M_C81, M_C85, M_C88: o_attr = '{1'b1, 1'b1, 1'b1, 1'b1};
         M_RET: begin
            o_attr.estop = 1'b1;
            if (i_code.sub == S_ZERO) begin
               o_attr.hist = 1'b0;
               o_attr.clr  = 1'b1;
            end else if (i_code.sub <= S_3) begin
               o_attr.clr = i_ret_attr[2'(i_code.sub - 4'h1)];
            end
         end
         M_CMD:  o_attr.clr = (i_code.sub == S_3);
         M_ENC:  o_attr.clr = 1'b0;
         M_HOME: o_attr.clr = (i_code.sub == S_3);
         M_MREC: o_attr.hist = 1'b0;
         M_CTL:  o_attr.clr = 1'b0;
         M_CHW:  o_attr.hist = (i_code.sub != S_5);
         default: o_attr.clr = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

/* sim/sacm_master.sv */
// partner: fieldbus master and discrete alarm clear pin
// assumes: bench calls its tasks; all changes just after i_clk rises
`timescale 1ns/1ps
`default_nettype none
module sacm_master (
   input  wire logic i_clk,
   input  wire logic i_stopped,
   output logic      o_comm_clear,
   output logic      o_pin
);
   initial begin
      o_comm_clear = 1'b0;
      o_pin        = 1'b0;
   end
   // one-cycle clear, held back up to 200 cycles while the axis still moves
   task automatic send_clear();
      int n;
      n = 0;
      while (!i_stopped && n < 200) begin
         @(posedge i_clk);
         n++;
      end
      @(posedge i_clk);
      o_comm_clear <= 1'b1;
      @(posedge i_clk);
      o_comm_clear <= 1'b0;
   endtask
   // pin level change, then wait out the synchroniser
   task automatic set_pin(input logic v);
      @(posedge i_clk);
      o_pin <= v;
      repeat (4) @(posedge i_clk);
   endtask
   // a pin held on blocks the clear: drop it first, then repeat
   task automatic retry_clear();
      set_pin(1'b0);
      send_clear();
   endtask
endmodule
`default_nettype wire

/* sim/sacm_top_test.sv */
// bench: drives sacm_top and compares with a model built from the rules
// assumes: sacm_master stands in for the fieldbus master and clear pin
`timescale 1ns/1ps
`default_nettype none
module sacm_top_test;
   import sacm_pkg::*;
   // ----------
   // signals
   // ----------
   localparam int OVL   = 20;
   localparam int IND   = 4;
   localparam int LIMIT = 20000;
   logic          i_clk, i_rst, i_we, i_re, i_alarm_raise;
   logic          i_retract_cond, i_retract_done, i_abs_enc_reset;
   logic [2:0]    i_addr, ra, fr;
   logic [DW-1:0] i_wdata, o_rdata, d;
   sacm_code_t    i_alarm_code, o_alarm_code, o_hist_code;
   logic          o_alarm, o_estop, o_fault_decel, o_retract_active;
   logic          o_ind_alarm, o_hist_wr, o_irq, comm_clr, pin, stopped;
   logic [2:0]    o_fault_reaction;
   logic [31:0]   seed;
   int            err_count, compares, cyc, t0;
   // short counts keep the run brief; expectations use the same values
   sacm_top #(.OVL_CYC(OVL), .IND_CYC(IND)) i_sacm_top (
      .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata),
      .i_alarm_raise(i_alarm_raise), .i_alarm_code(i_alarm_code),
      .i_retract_cond(i_retract_cond), .i_retract_done(i_retract_done),
      .i_comm_clear(comm_clr), .i_alarm_clear_input(pin),
      .i_abs_enc_reset(i_abs_enc_reset), .o_alarm(o_alarm),
      .o_alarm_code(o_alarm_code), .o_estop(o_estop),
      .o_fault_decel(o_fault_decel), .o_fault_reaction(o_fault_reaction),
      .o_retract_active(o_retract_active), .o_ind_alarm(o_ind_alarm),
      .o_hist_wr(o_hist_wr), .o_hist_code(o_hist_code), .o_irq(o_irq));
   assign stopped = ~o_retract_active;
   sacm_master i_sacm_master (.i_clk(i_clk), .i_stopped(stopped),
      .o_comm_clear(comm_clr), .o_pin(pin));
   always #5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         err_count++;
         wrap_up();
      end
   end
   // ----------
   // tasks
   // ----------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic exp_clr(input sacm_code_t c, input logic [2:0] r);
      if (c.main == M_RET) return r[c.sub - 4'h1];
      return (c.main == M_CMD || c.main == M_HOME);
   endfunction
   task automatic chk16(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      chk16({15'h0, g}, {15'h0, e});
   endtask
   task automatic chkc(input sacm_code_t g, input sacm_code_t e);
      chk16({4'h0, g}, {4'h0, e});
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] v);
      @(posedge i_clk);
      i_we    <= 1'b1;
      i_addr  <= a;
      i_wdata <= v;
      @(posedge i_clk);
      i_we <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [15:0] v);
      @(posedge i_clk);
      i_re   <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_re <= 1'b0;
      #1 v = o_rdata;
   endtask
   task automatic raise(input sacm_code_t c);
      @(posedge i_clk);
      i_alarm_raise <= 1'b1;
      i_alarm_code  <= c;
      @(posedge i_clk);
      i_alarm_raise <= 1'b0;
      #1;
   endtask
   task automatic pulse(input logic done);
      @(posedge i_clk);
      if (done) i_retract_done <= 1'b1;
      else i_abs_enc_reset <= 1'b1;
      @(posedge i_clk);
      {i_retract_done, i_abs_enc_reset} <= 2'b00;
      @(posedge i_clk);
      #1;
   endtask
   task automatic clr();
      i_sacm_master.send_clear();
      repeat (2) @(posedge i_clk);
      #1;
   endtask
   task automatic do_reset();
      i_sacm_master.set_pin(1'b0);
      @(posedge i_clk);
      i_rst          <= 1'b1;
      i_retract_cond <= 1'b0;
      repeat (6) @(posedge i_clk);
      i_rst <= 1'b0;
   endtask
   task automatic wrap_up();
      if (err_count == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ----------
   // sequence
   // ----------
   sacm_code_t tab[$] = '{'{M_CMD, S_3}, '{M_HOME, S_3}, '{M_ENC, S_ZERO},
      '{M_MREC, S_ZERO}, '{M_MREC, 4'h4}, '{M_CTL, 4'h2}, '{M_CTL, 4'h8},
      '{M_CHW, 4'h2}, '{M_CHW, S_3}, '{M_RET, 4'h1}, '{M_RET, 4'h2}, '{M_RET, S_3}};
   initial begin
      {i_clk, i_we, i_re, i_alarm_raise, i_retract_cond} = '0;
      {i_retract_done, i_abs_enc_reset, i_addr, i_wdata} = '0;
      {err_count, compares, cyc} = '0;
      i_alarm_code = '0;
      i_rst        = 1'b1;
      seed         = 32'h06381921;
      do_reset();
      rd(REG_CTRL, d);
      chk16(d, CTRL_RST);
      seed = lfsr(seed);
      wr(REG_MASK, {12'h0, seed[3:0]});
      rd(REG_MASK, d);
      chk16(d, {12'h0, seed[3:0]});
      wr(REG_ALRM, 16'hffff);
      rd(REG_ALRM, d);
      chk16(d, 16'h0000);
      rd(3'h5, d);
      chk16(d, 16'h0000);
      // raise, mask and clear of the interrupt around one alarm
      wr(REG_MASK, 16'h0001);
      raise('{M_CMD, S_3});
      chk1(o_hist_wr, 1'b1);
      chkc(o_hist_code, '{M_CMD, S_3});
      rd(REG_ALRM, d);
      chk16(d, {4'h8, M_CMD, S_3});
      chk1(o_irq, 1'b1);
      rd(REG_STAT, d);
      chk16(d, 16'h0001);
      @(posedge i_clk);
      #1 chk1(o_irq, 1'b0);
      clr();
      chk1(o_alarm, 1'b0);
      rd(REG_STAT, d);
      chk16(d, 16'h0002);
      chk1(o_irq, 1'b0);
      // attribute table, retract clear bits drawn at random
      foreach (tab[k]) begin
         do_reset();
         seed = lfsr(seed);
         ra   = seed[2:0];
         wr(REG_CTRL, {9'h0, ra, 4'h0});
         raise(tab[k]);
         chk1(o_hist_wr, tab[k].main != M_MREC);
         clr();
         chk1(o_alarm, !exp_clr(tab[k], ra));
         if (!exp_clr(tab[k], ra)) chkc(o_alarm_code, tab[k]);
         rd(REG_STAT, d);
         chk16(d, exp_clr(tab[k], ra) ? 16'h0003 : 16'h0005);
      end
      // clear pin against the comm clear
      do_reset();
      wr(REG_CTRL, 16'h1000);
      i_sacm_master.set_pin(1'b1);
      raise('{M_HOME, S_3});
      clr();
      chk1(o_alarm, 1'b1);
      i_sacm_master.retry_clear();
      repeat (2) @(posedge i_clk);
      #1 chk1(o_alarm, 1'b0);
      raise('{M_HOME, S_3});
      i_sacm_master.set_pin(1'b1);
      repeat (2) @(posedge i_clk);
      #1 chk1(o_alarm, 1'b0);
      wr(REG_CTRL, 16'h0000);
      raise('{M_CMD, S_3});
      clr();
      chk1(o_alarm, 1'b0);
      // overload hold time
      do_reset();
      raise('{M_OVL, S_ZERO});
      t0 = cyc;
      clr();
      while (cyc < t0 + OVL - 3) @(posedge i_clk);
      #1 chk1(o_alarm, 1'b1);
      while (cyc < t0 + OVL + 4) @(posedge i_clk);
      #1 chk1(o_alarm, 1'b0);
      // absolute alarms: port reset, then register reset and clear
      do_reset();
      raise('{M_ABS1, S_ZERO});
      clr();
      chk1(o_alarm, 1'b1);
      pulse(1'b0);
      clr();
      chk1(o_alarm, 1'b0);
      raise('{M_ABS2, S_ZERO});
      wr(REG_CMD, 16'h0001);
      repeat (2) @(posedge i_clk);
      #1 chk1(o_alarm, 1'b1);
      wr(REG_CMD, 16'h0002);
      wr(REG_CMD, 16'h0001);
      repeat (2) @(posedge i_clk);
      #1 chk1(o_alarm, 1'b0);
      // comm alarm under every sequence setting
      for (int s = 0; s < 8; s++) begin
         do_reset();
         seed = lfsr(seed);
         fr   = seed[2:0];
         wr(REG_CTRL, {5'h0, fr, 5'h0, 3'(s)});
         raise('{M_C80, S_ZERO});
         chk1(o_estop, s >= 4);
         chk1(o_fault_decel, 1'b1);
         chk16({13'h0, o_fault_reaction}, {13'h0, fr});
         chk1(o_ind_alarm, 1'b0);
         repeat (IND + 2) @(posedge i_clk);
         #1 chk1(o_ind_alarm, 1'b1);
      end
      // retract path: alarm held back until the retract ends
      do_reset();
      wr(REG_CTRL, 16'h0010);
      @(posedge i_clk);
      i_retract_cond <= 1'b1;
      raise('{M_RET, 4'h1});
      chk1(o_retract_active, 1'b1);
      chk1(o_alarm, 1'b0);
      pulse(1'b1);
      chk1(o_alarm, 1'b1);
      chk1(o_estop, 1'b1);
      clr();
      chk1(o_alarm, 1'b0);
      wrap_up();
   end
endmodule
`default_nettype wire
